// ### include/transceiver_spi_mode_pkg.sv
/*
  shared constants and types for the serial port and power-mode control block.
  assumes a single 50 MHz core clock; all times below are turned into cycle counts here.
*/
package transceiver_spi_mode_pkg;
  // core clock rate
  localparam int unsigned CLK_HZ = 50_000_000;
  // transition times, in their own units
  localparam int unsigned OFF_WAKE_MS = 10;    // off to idle, shortest figure
  localparam int unsigned HIB_WAKE_MS = 7;     // hibernate to idle, shortest figure
  localparam int unsigned DOZE_WAKE_US = 300;  // doze to idle, plus one clock-out period
  localparam int unsigned WARM_US = 144;       // idle to receive or transmit, longest figure
  // cycle counts: least times round up, longest times round down
  localparam int unsigned OFF_WAKE_CYC = (OFF_WAKE_MS * (CLK_HZ / 1000) + 0);
  localparam int unsigned HIB_WAKE_CYC = (HIB_WAKE_MS * (CLK_HZ / 1000) + 0);
  localparam int unsigned DOZE_BASE_CYC = (DOZE_WAKE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned WARM_CYC = (WARM_US * CLK_HZ) / 1_000_000;
  localparam int unsigned US_TICK_CYC = CLK_HZ / 1_000_000;
  localparam int WAIT_W = 20;
  localparam logic [5:0] US_TICK_LAST = 6'(US_TICK_CYC - 1);
  // serial frame layout
  localparam int ADDR_W = 6;
  localparam int WORD_W = 16;
  localparam int HDR_READ_BIT = 7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // internal word addresses with side effects
  localparam logic [5:0] REG_MODE = 6'h00;
  localparam logic [5:0] REG_TIMER_CMP = 6'h06;
  localparam logic [5:0] REG_CLOCK_OUTPUT_PIN_CFG = 6'h07;
  localparam logic [5:0] REG_PA = 6'h0c;
  // clock-out configuration fields
  localparam int CLOCK_OUTPUT_PIN_EN_BIT = 9;
  localparam int CLOCK_OUTPUT_PIN_DIV_W = 9;
  localparam int unsigned CLOCK_OUTPUT_PIN_MAX_HZ = 1_000_000;
  localparam logic [8:0] CLOCK_OUTPUT_PIN_DIV_MIN_SLOW = 9'(CLK_HZ / (2 * CLOCK_OUTPUT_PIN_MAX_HZ) - 1);
  // values after reset
  localparam logic [15:0] CLOCK_OUTPUT_PIN_CFG_RST = 16'h01ff;
  localparam logic [15:0] PA_RST = 16'h00bc;
  localparam logic [15:0] TIMER_CMP_RST = 16'h0000;
  // power amplifier levels
  localparam logic [7:0] PA_NOMINAL = 8'hbc;
  localparam logic [7:0] PA_MAXIMUM = 8'hff;
  // mode commands written to REG_MODE
  localparam logic [15:0] CMD_IDLE = 16'h0000;
  localparam logic [15:0] CMD_RX = 16'h0001;
  localparam logic [15:0] CMD_TX = 16'h0002;
  localparam logic [15:0] CMD_DOZE = 16'h0003;
  localparam logic [15:0] CMD_HIB = 16'h0004;
  // power modes
  typedef enum logic [3:0] {
    M_OFF, M_IDLE, M_HIB, M_HIB_WAKE, M_DOZE, M_DOZE_WAKE, M_RX_WARM, M_RX, M_TX_WARM, M_TX
  } mode_state_t;
endpackage : transceiver_spi_mode_pkg

// ### src/mem_word_store.sv
/*
  word store behind the serial port: 64 words of 16 bits, registered read.
  assumes one writer and one reader on the core clock; contents are kept in every mode.
*/
`timescale 1ns/1ps
module mem_word_store (
  input wire logic i_clk,
  input wire logic i_wr_en,
  input wire logic [transceiver_spi_mode_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [transceiver_spi_mode_pkg::WORD_W-1:0] i_wr_data,
  input wire logic [transceiver_spi_mode_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [transceiver_spi_mode_pkg::WORD_W-1:0] o_rd_data
);
  import transceiver_spi_mode_pkg::*;

  // no reset on the array: data must survive low-power modes
  logic [WORD_W-1:0] store [0:(1<<ADDR_W)-1];

  // write port
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      store[i_wr_addr] <= i_wr_data;
    end
  end

  // read port, one cycle of latency
  always_ff @(posedge i_clk) begin
    o_rd_data <= store[i_rd_addr];
  end
endmodule : mem_word_store

// ### src/transceiver_spi_mode_ctrl.sv
/*
  serial slave port and power-mode sequencer of a low-power radio transceiver.
  assumes the host is the serial master (clock idle low, sample on rise), and that pins
  are asynchronous to i_clk; the serial clock must stay well below a quarter of i_clk.
*/
`timescale 1ns/1ps
// Summary of operation
// - leave off, enter idle after reset release
// - idle accepts serial commands from host
// - doze and hibernate entered only by command
// - outputs released during reset; idle after 10ms
// - hibernate: oscillator, serial stopped; attention wakes, 7ms
// - doze clock-out only if enabled, slow enough
// - doze wakes on attention or timer match
// - doze wake takes 300us plus clock-out period
// - idle: oscillator, clock-out and serial active
// - receiver working within 144us from idle
// - transmitter working within 144us from idle
// - slave only, host drives clock, 8-bit bursts
// - sample on rising edge, change on falling
// - data in on mosi, out on miso
// - serial transfers moved by core clock
// - power register: 0xbc nominal, 0xff maximum
// - bursts are eight bits, msb first
// - payload even bytes, one direction only
module transceiver_spi_mode_ctrl #(
  parameter int unsigned OFF_WAKE_CYC = transceiver_spi_mode_pkg::OFF_WAKE_CYC,
  parameter int unsigned HIB_WAKE_CYC = transceiver_spi_mode_pkg::HIB_WAKE_CYC,
  parameter int unsigned DOZE_BASE_CYC = transceiver_spi_mode_pkg::DOZE_BASE_CYC,
  parameter int unsigned WARM_CYC = transceiver_spi_mode_pkg::WARM_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_serial_clock_in,
  input wire logic i_cs_b,
  input wire logic i_mosi,
  input wire logic i_wake_attention_in,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_clock_output_pin,
  output logic o_clock_output_pin_oe,
  output logic o_osc_on,
  output logic o_serial_active,
  output logic o_rx_on,
  output logic o_tx_on,
  output logic [7:0] o_pa_level
);
  import transceiver_spi_mode_pkg::*;

  // synchronisers, bits {attention, mosi, select, clock}: stage 1 feeds stage 2 only
  logic [3:0] pin_s1_reg, pin_s2_reg;
  logic sclk_s2, sclk_s3, cs_s2, mosi_s2, wake_attention_in_s2; // stage 3 only for clock edge detection
  mode_state_t state_reg;            // power mode
  logic [WAIT_W-1:0] wait_reg;       // transition countdown
  logic serial_on, cs_act;           // serial port usable in this mode; selected as well
  logic rise, fall;                  // serial clock edges
  logic [2:0] bit_cnt_reg;           // bit within burst
  logic [7:0] sr_reg;                // incoming shift register
  logic hdr_done_reg;                // header burst received
  logic hi_pending_reg;              // first byte of a word done
  logic rd_reg;                      // transaction is a read
  logic [ADDR_W-1:0] addr_reg, wr_addr_reg; // addressed word, and where a finished word goes
  logic [7:0] hi_byte_reg;           // high byte of a write word
  logic byte_done;                   // eighth rising edge
  logic [7:0] byte_val;              // completed byte
  logic wr_en_reg;                   // word write pulse
  logic [WORD_W-1:0] wr_data_reg, mem_rd_data; // finished word, store read data
  logic [WORD_W-1:0] rd_word;        // word to send
  logic [WORD_W-1:0] out_sr_reg;     // outgoing shift register
  logic [WORD_W-1:0] mode_word_reg, cmp_reg, clock_output_pin_cfg_reg, pa_reg;
  logic cmd_valid;                   // mode command written
  logic [5:0] tick_reg;              // microsecond divider
  logic [15:0] us_cnt_reg;           // timer
  logic cmp_armed_reg, cmp_match;    // comparator programmed, and hit
  logic [CLOCK_OUTPUT_PIN_DIV_W-1:0] clock_output_pin_div;
  logic [CLOCK_OUTPUT_PIN_DIV_W-1:0] clock_output_pin_cnt_reg;
  logic clock_output_pin_run;
  logic [WAIT_W-1:0] clock_output_pin_period;

  // two flip-flops on every pin input, reset to each pin's idle level so no false edge follows
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1_reg <= 4'ha;
      pin_s2_reg <= 4'ha;
      sclk_s3 <= 1'b0;
    end else begin
      pin_s1_reg <= {i_wake_attention_in, i_mosi, i_cs_b, i_serial_clock_in};
      pin_s2_reg <= pin_s1_reg;
      sclk_s3 <= sclk_s2;
    end
  end
  assign {wake_attention_in_s2, mosi_s2, cs_s2, sclk_s2} = pin_s2_reg;

  // serial port dead outside idle, receive and transmit
  assign serial_on = (state_reg == M_IDLE) || (state_reg == M_RX) || (state_reg == M_TX);
  assign cs_act = !cs_s2 && serial_on;
  // edges of the host's clock; we never drive it
  assign rise = sclk_s2 && !sclk_s3 && cs_act;
  assign fall = !sclk_s2 && sclk_s3 && cs_act;
  assign byte_done = rise && (bit_cnt_reg == BIT_LAST);
  assign byte_val = {sr_reg[6:0], mosi_s2};

  // burst framing, bit and byte bookkeeping
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_reg <= 3'h0;
      sr_reg <= 8'h00;
      hdr_done_reg <= 1'b0;
      hi_pending_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= '0;
      hi_byte_reg <= 8'h00;
    end else if (!cs_act) begin
      // select high ends the transaction; a half word is dropped
      bit_cnt_reg <= 3'h0;
      hdr_done_reg <= 1'b0;
      hi_pending_reg <= 1'b0;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      sr_reg <= byte_val;
      if (byte_done) begin
        if (!hdr_done_reg) begin
          // header: read flag and word address
          hdr_done_reg <= 1'b1;
          rd_reg <= byte_val[HDR_READ_BIT];
          addr_reg <= byte_val[ADDR_W-1:0];
        end else begin
          // payload goes in byte pairs, high byte first
          hi_pending_reg <= !hi_pending_reg;
          if (!hi_pending_reg) begin
            hi_byte_reg <= byte_val;
          end
        end
      end
    end
  end

  // completed write words handed to the core side
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_en_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      // mosi ignored on reads: no full duplex
      wr_en_reg <= byte_done && hdr_done_reg && hi_pending_reg && !rd_reg;
      if (byte_done && hi_pending_reg) begin
        wr_addr_reg <= addr_reg;
        wr_data_reg <= {hi_byte_reg, byte_val};
      end
    end
  end

  // word store for everything without side effects
  mem_word_store u_store (
    .i_clk(i_clk),
    .i_wr_en(wr_en_reg),
    .i_wr_addr(wr_addr_reg),
    .i_wr_data(wr_data_reg),
    .i_rd_addr(addr_reg),
    .o_rd_data(mem_rd_data)
  );

  // control words live in flops so they have reset values
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_word_reg <= CMD_IDLE;
      cmp_reg <= TIMER_CMP_RST;
      clock_output_pin_cfg_reg <= CLOCK_OUTPUT_PIN_CFG_RST;
      pa_reg <= PA_RST;
    end else if (wr_en_reg) begin
      unique case (wr_addr_reg)
        REG_MODE: mode_word_reg <= wr_data_reg;
        REG_TIMER_CMP: cmp_reg <= wr_data_reg;
        REG_CLOCK_OUTPUT_PIN_CFG: clock_output_pin_cfg_reg <= wr_data_reg;
        REG_PA: pa_reg <= wr_data_reg;
        default: ;
      endcase
    end
  end

  assign cmd_valid = wr_en_reg && (wr_addr_reg == REG_MODE);

  // read-back source
  always_comb begin
    unique case (addr_reg)
      REG_MODE: rd_word = mode_word_reg;
      REG_TIMER_CMP: rd_word = cmp_reg;
      REG_CLOCK_OUTPUT_PIN_CFG: rd_word = clock_output_pin_cfg_reg;
      REG_PA: rd_word = pa_reg;
      default: rd_word = mem_rd_data;
    endcase
  end

  // miso changes on falling edges; msb presented after last header edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_sr_reg <= '0;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= cs_act && hdr_done_reg && rd_reg;
      if (fall && hdr_done_reg && rd_reg) begin
        if (bit_cnt_reg == 3'h0 && !hi_pending_reg) begin
          // word boundary: fetch new word
          o_miso <= rd_word[WORD_W-1];
          out_sr_reg <= {rd_word[WORD_W-2:0], 1'b0};
        end else begin
          o_miso <= out_sr_reg[WORD_W-1];
          out_sr_reg <= {out_sr_reg[WORD_W-2:0], 1'b0};
        end
      end
    end
  end

  // microsecond timer and its comparator
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_reg <= 6'h00;
      us_cnt_reg <= 16'h0000;
      cmp_armed_reg <= 1'b0;
    end else begin
      if (tick_reg == US_TICK_LAST) begin
        tick_reg <= 6'h00;
        us_cnt_reg <= us_cnt_reg + 16'h0001;
      end else begin
        tick_reg <= tick_reg + 6'h01;
      end
      // programming wins over a clear in the same cycle
      if (wr_en_reg && wr_addr_reg == REG_TIMER_CMP) begin
        cmp_armed_reg <= 1'b1;
      end else if (state_reg == M_DOZE && cmp_match) begin
        cmp_armed_reg <= 1'b0;
      end
    end
  end

  assign cmp_match = cmp_armed_reg && (us_cnt_reg == cmp_reg[15:0]);
  assign clock_output_pin_div = clock_output_pin_cfg_reg[CLOCK_OUTPUT_PIN_DIV_W-1:0];
  assign clock_output_pin_period = WAIT_W'({clock_output_pin_div, 1'b0}) + WAIT_W'(2);

  // power-mode sequencer
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= M_OFF;
      wait_reg <= WAIT_W'(OFF_WAKE_CYC - 1);
    end else begin
      unique case (state_reg)
        M_IDLE, M_RX, M_TX: begin
          if (cmd_valid) begin
            unique case (wr_data_reg)
              CMD_RX: begin
                state_reg <= M_RX_WARM;
                wait_reg <= WAIT_W'(WARM_CYC - 1);
              end
              CMD_TX: begin
                state_reg <= M_TX_WARM;
                wait_reg <= WAIT_W'(WARM_CYC - 1);
              end
              CMD_DOZE: state_reg <= M_DOZE;
              CMD_HIB: state_reg <= M_HIB;
              CMD_IDLE: state_reg <= M_IDLE;
              default: ;
            endcase
          end
        end
        M_HIB: begin
          if (!wake_attention_in_s2) begin
            state_reg <= M_HIB_WAKE;
            wait_reg <= WAIT_W'(HIB_WAKE_CYC - 1);
          end
        end
        M_DOZE: begin
          if (!wake_attention_in_s2 || cmp_match) begin
            state_reg <= M_DOZE_WAKE;
            wait_reg <= WAIT_W'(DOZE_BASE_CYC - 1) + clock_output_pin_period;
          end
        end
        M_OFF, M_HIB_WAKE, M_DOZE_WAKE, M_RX_WARM, M_TX_WARM: begin
          // one shared countdown; off and both wake states end in idle
          if (wait_reg == '0) begin
            state_reg <= (state_reg == M_RX_WARM) ? M_RX : ((state_reg == M_TX_WARM) ? M_TX : M_IDLE);
          end else begin
            wait_reg <= wait_reg - WAIT_W'(1);
          end
        end
      endcase
    end
  end

  // clock-out: in doze only if enabled and at or below the frequency limit
  assign clock_output_pin_run = o_osc_on && ((state_reg != M_DOZE) ||
                    (clock_output_pin_cfg_reg[CLOCK_OUTPUT_PIN_EN_BIT] && clock_output_pin_div >= CLOCK_OUTPUT_PIN_DIV_MIN_SLOW));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clock_output_pin_cnt_reg <= '0;
      o_clock_output_pin <= 1'b0;
    end else if (!clock_output_pin_run) begin
      // parked low so the pin does not burn power
      clock_output_pin_cnt_reg <= clock_output_pin_div;
      o_clock_output_pin <= 1'b0;
    end else if (clock_output_pin_cnt_reg == '0) begin
      clock_output_pin_cnt_reg <= clock_output_pin_div;
      o_clock_output_pin <= !o_clock_output_pin;
    end else begin
      clock_output_pin_cnt_reg <= clock_output_pin_cnt_reg - CLOCK_OUTPUT_PIN_DIV_W'(1);
    end
  end

  // status outputs follow the mode, and the power level follows its register, one cycle late
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_clock_output_pin_oe <= 1'b0;
      o_osc_on <= 1'b0;
      o_serial_active <= 1'b0;
      o_rx_on <= 1'b0;
      o_tx_on <= 1'b0;
      o_pa_level <= PA_RST[7:0];
    end else begin
      o_clock_output_pin_oe <= (state_reg != M_OFF);
      o_osc_on <= !(state_reg inside {M_OFF, M_HIB, M_HIB_WAKE});
      o_serial_active <= serial_on;
      o_rx_on <= (state_reg == M_RX);
      o_tx_on <= (state_reg == M_TX);
      o_pa_level <= pa_reg[7:0];
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_word_boundary;
    fall && hdr_done_reg && rd_reg && bit_cnt_reg == 3'h0 && !hi_pending_reg;
  endsequence
  sequence s_doze_wake_req;
    state_reg == M_DOZE && (!wake_attention_in_s2 || cmp_match);
  endsequence

  a_miso_release: assert property (!cs_act |=> !o_miso_oe)
    else $error("miso driven while deselected");
  a_miso_msb: assert property (s_word_boundary |=> o_miso == $past(rd_word[WORD_W-1]))
    else $error("word msb not presented first");
  a_header_latch: assert property (byte_done && !hdr_done_reg |=> rd_reg == $past(byte_val[HDR_READ_BIT])
    && addr_reg == $past(byte_val[ADDR_W-1:0]))
    else $error("header not latched");
  a_off_wake: assert property (state_reg == M_OFF && wait_reg == '0 |=> state_reg == M_IDLE)
    else $error("off did not reach idle");
  a_doze_entry: assert property ($changed(state_reg) && state_reg == M_DOZE |-> $past(cmd_valid))
    else $error("doze entered without command");
  a_hib_serial: assert property (state_reg == M_HIB |-> !serial_on && !rise)
    else $error("serial alive in hibernate");
  a_doze_wake: assert property (s_doze_wake_req |=> state_reg == M_DOZE_WAKE
    && wait_reg == WAIT_W'(DOZE_BASE_CYC - 1) + $past(clock_output_pin_period))
    else $error("doze wake wrong");
  a_clock_output_pin_gate: assert property (state_reg == M_DOZE && !clock_output_pin_run |=> !o_clock_output_pin)
    else $error("clock-out ran in doze");
  a_rx_warm: assert property (state_reg == M_RX_WARM && wait_reg == '0 |=> state_reg == M_RX ##1 o_rx_on)
    else $error("receiver late");
  a_pa_write: assert property (wr_en_reg && wr_addr_reg == REG_PA
    |=> ##1 o_pa_level == $past(wr_data_reg[7:0], 2))
    else $error("power level not applied");
endmodule : transceiver_spi_mode_ctrl

// ### test/host_serial_master.sv
/*
  host-side serial master model: select, serial clock and host data out, reply data captured.
  assumes a free-running core clock i_clk; every pin changes just after its falling edge.
*/
`timescale 1ns/1ps
module host_serial_master #(
  parameter int HALF_CYC = 6  // clock phase in core cycles, twice the minimum the port needs
) (
  input wire logic i_clk,
  input wire logic i_miso,
  input wire logic i_miso_oe,
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_mosi
);
  logic last_bit;  // last reply bit seen, inverted while the line floats

  // pins parked: clock low, deselected
  initial begin
    o_sclk = 1'b0;  // clock idles low outside frames
    o_cs_b = 1'b1;
    o_mosi = 1'b0;
    last_bit = 1'b0;
  end

  // one eight-bit burst, msb first
  task automatic burst(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge i_clk);
      o_sclk <= 1'b0;  // data changes with the falling clock
      o_mosi <= drive ? tx[i] : ~o_mosi;  // unused line keeps moving so it never looks valid
      repeat (HALF_CYC) @(negedge i_clk);
      o_sclk <= 1'b1;  // rising clock: both sides sample
      last_bit = i_miso_oe ? i_miso : ~last_bit;
      rx[i] = last_bit;
      repeat (HALF_CYC - 1) @(negedge i_clk);
    end
  endtask : burst

  // header then one word, high byte first, one direction only
  task automatic frame(input logic rd, input logic [5:0] addr, input logic [15:0] wd,
                       output logic [15:0] rdat);
    logic [7:0] junk;
    @(negedge i_clk);
    o_cs_b <= 1'b0;
    burst({rd, 1'b0, addr}, 1'b1, junk);
    burst(wd[15:8], !rd, rdat[15:8]);
    burst(wd[7:0], !rd, rdat[7:0]);
    repeat (HALF_CYC) @(negedge i_clk);
    o_sclk <= 1'b0;
    repeat (HALF_CYC) @(negedge i_clk);
    o_cs_b <= 1'b1;  // select released after the final burst
    repeat (2 * HALF_CYC) @(negedge i_clk);
  endtask : frame

  // clock pulses with select high, only when a scenario asks for them
  task automatic stray(input int n);
    repeat (2 * n) begin
      repeat (HALF_CYC) @(negedge i_clk);
      o_sclk <= ~o_sclk;
    end
  endtask : stray
endmodule : host_serial_master

// ### test/test_transceiver_spi_mode_ctrl.sv
/*
  self-checking bench for the serial port and power-mode block, with a host master model.
  assumes shortened wake counts; latencies are stamped with a free cycle counter.
*/
`timescale 1ns/1ps
module test_transceiver_spi_mode_ctrl;
  import transceiver_spi_mode_pkg::*;
  localparam int OFF_W = 20;  // shortened counts, expectations derive from these
  localparam int HIB_W = 15;
  localparam int DOZE_W = 10;
  localparam int WARM_W = 8;
  logic i_clk, i_rst_b, i_wake_attention_in, sclk, cs_b, mosi;
  logic o_miso, o_miso_oe, o_clock_output_pin, o_clock_output_pin_oe;
  logic o_osc_on, o_serial_active, o_rx_on, o_tx_on;
  logic [7:0] o_pa_level;
  logic [31:0] lfsr_state;
  logic [15:0] mem_model [int];  // expected store contents
  logic [15:0] rd;
  logic [5:0] a;
  int fails, checks, cyc, rel_t, up_t, rx_t, tx_t, rise_t, att_t, tmr, tog;

  transceiver_spi_mode_ctrl #(.OFF_WAKE_CYC(OFF_W), .HIB_WAKE_CYC(HIB_W), .DOZE_BASE_CYC(DOZE_W),
    .WARM_CYC(WARM_W)) i_transceiver_spi_mode_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_serial_clock_in(sclk), .i_cs_b(cs_b), .i_mosi(mosi), .i_wake_attention_in(i_wake_attention_in),
    .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_clock_output_pin(o_clock_output_pin),
    .o_clock_output_pin_oe(o_clock_output_pin_oe), .o_osc_on(o_osc_on), .o_serial_active(o_serial_active),
    .o_rx_on(o_rx_on), .o_tx_on(o_tx_on), .o_pa_level(o_pa_level));
  host_serial_master i_host_serial_master (.i_clk(i_clk), .i_miso(o_miso), .i_miso_oe(o_miso_oe),
    .o_sclk(sclk), .o_cs_b(cs_b), .o_mosi(mosi));

  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // cycle counter and edge stamps, so late checks still see exact latencies
  always @(posedge i_clk) cyc <= cyc + 1;
  always @(posedge o_serial_active) up_t = cyc;
  always @(posedge o_rx_on) rx_t = cyc;
  always @(posedge o_tx_on) tx_t = cyc;
  always @(posedge sclk) rise_t = cyc;
  always @(o_clock_output_pin) tog++;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // latency between two stamps must lie in a window
  task automatic chk_lat(input string what, input int from, input int to, input int lo, input int hi);
    chk_bit(what, 1'b1, (to - from >= lo) && (to - from <= hi));
  endtask : chk_lat

  // bounded wait for a status flag: 0 serial, 1 receive, 2 transmit
  task automatic wait_flag(input int sel, input int lim);
    for (int n = 0; n < lim; n++) begin
      if ((sel == 0 && o_serial_active === 1'b1) || (sel == 1 && o_rx_on === 1'b1) ||
          (sel == 2 && o_tx_on === 1'b1)) break;
      @(negedge i_clk);
    end
  endtask : wait_flag

  task automatic wr(input logic [5:0] adr, input logic [15:0] d);
    i_host_serial_master.frame(1'b0, adr, d, rd);
  endtask : wr

  task automatic rdw(input logic [5:0] adr);
    i_host_serial_master.frame(1'b1, adr, 16'h0000, rd);
  endtask : rdw

  task automatic finish_test;
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // hang guard, far beyond the roughly ten thousand cycles the sequence needs
  initial begin
    #1_000_000;
    fails++;
    finish_test();
  end

  // main sequence
  initial begin
    {fails, checks, cyc, up_t, rx_t, tx_t, rise_t} = '0;
    i_rst_b = 1'b0;
    i_wake_attention_in = 1'b1;
    lfsr_state = 32'hb1ae;
    repeat (3) @(negedge i_clk);
    chk_bit("miso enable in reset", 1'b0, o_miso_oe);
    chk_bit("clock out enable in reset", 1'b0, o_clock_output_pin_oe);
    repeat (2) @(negedge i_clk);
    i_rst_b = 1'b1;
    rel_t = cyc;
    wait_flag(0, 2 * OFF_W);
    chk_lat("off to idle", rel_t, up_t, OFF_W, OFF_W + 8);
    chk_bit("clock out enabled", 1'b1, o_clock_output_pin_oe);
    chk_word("power reset", 16'h00bc, {8'h00, o_pa_level});
    // random words to plain store addresses
    for (int k = 0; k < 6; k++) begin
      lfsr_state = lfsr_next(lfsr_state);
      a = 6'h10 + {1'b0, lfsr_state[4:0]};
      mem_model[a] = lfsr_state[31:16];
      wr(a, lfsr_state[31:16]);
    end
    foreach (mem_model[k]) begin
      rdw(6'(k));
      chk_word("stored word", mem_model[k], rd);
    end
    wr(REG_PA, 16'h00ff);
    chk_word("power max", 16'h00ff, {8'h00, o_pa_level});
    wr(REG_PA, 16'h00bc);
    chk_word("power nominal", 16'h00bc, {8'h00, o_pa_level});
    i_host_serial_master.stray(8);
    chk_bit("miso enable deselected", 1'b0, o_miso_oe);
    rdw(REG_PA);
    chk_word("power readback", 16'h00bc, rd);
    // receive and transmit warm-up
    wr(REG_MODE, 16'h0001);
    wait_flag(1, 100);
    chk_lat("receive warm-up", rise_t, rx_t, WARM_W, WARM_W + 8);
    wr(REG_MODE, 16'h0002);
    wait_flag(2, 100);
    chk_lat("transmit warm-up", rise_t, tx_t, WARM_W, WARM_W + 8);
    chk_bit("receiver off in transmit", 1'b0, o_rx_on);
    wr(REG_MODE, 16'h0000);
    chk_bit("transmitter off in idle", 1'b0, o_tx_on);
    // doze, clock-out disabled, divider 4
    wr(REG_CLOCK_OUTPUT_PIN_CFG, 16'h0004);
    wr(REG_MODE, 16'h0003);
    repeat (20) @(negedge i_clk);
    chk_bit("serial off in doze", 1'b0, o_serial_active);
    chk_bit("oscillator in doze", 1'b1, o_osc_on);
    chk_bit("clock out parked in doze", 1'b0, o_clock_output_pin);
    wr(REG_PA, 16'h00ff);
    i_wake_attention_in = 1'b0;
    att_t = cyc;
    wait_flag(0, 200);
    chk_lat("doze wake", att_t, up_t, DOZE_W + 10, DOZE_W + 18);
    i_wake_attention_in = 1'b1;
    rdw(REG_PA);
    chk_word("power after doze", 16'h00bc, rd);
    // hibernate
    wr(REG_MODE, 16'h0004);
    repeat (20) @(negedge i_clk);
    chk_bit("oscillator in hibernate", 1'b0, o_osc_on);
    i_wake_attention_in = 1'b0;
    att_t = cyc;
    wait_flag(0, 200);
    chk_lat("hibernate wake", att_t, up_t, HIB_W, HIB_W + 8);
    i_wake_attention_in = 1'b1;
    rdw(a);
    chk_word("retained word", mem_model[a], rd);
    chk_bit("miso enable after frame", 1'b0, o_miso_oe);
    // doze with clock-out on at the smallest legal divider, woken by the timer comparator
    wr(REG_CLOCK_OUTPUT_PIN_CFG, 16'h0218);
    tmr = (cyc - rel_t) / US_TICK_CYC + 40;
    wr(REG_TIMER_CMP, 16'(tmr));
    wr(REG_MODE, 16'h0003);
    tog = 0;
    repeat (200) @(negedge i_clk);
    chk_lat("clock out toggles in doze", 0, tog, 7, 9);
    wait_flag(0, 3000);
    chk_lat("timer wake", rel_t + US_TICK_CYC * tmr, up_t, DOZE_W + 50, DOZE_W + 58);
    finish_test();
  end
endmodule : test_transceiver_spi_mode_ctrl
